// ==== verilog/branch_decode_consts.svh ====
// Constants of the branch decode and stretch timing block
// Assumes inclusion by bare name from every file that needs offsets or counts
`ifndef BRANCH_DECODE_CONSTS_SVH
`define BRANCH_DECODE_CONSTS_SVH

// ==========
// Special function space
`define SFR_CLOCK_CONTROL_ADDR  8'h8e
`define STRETCH_LSB             0
`define STRETCH_MSB             2
`define TIMER_FAST_BIT          3
`define STRETCH_RESET           3'h1
`define CLOCK_CONTROL_RESET     8'h01

// ==========
// CPU control register
`define CLKSEL_LSB              3
`define CLKSEL_MSB              4
`define CLKSEL_12MHZ            2'h0
`define CLKSEL_24MHZ            2'h1
`define CLKSEL_48MHZ            2'h2
`define CPU_CONTROL_RESET       8'h00

// ==========
// Timing
`define CLK_PER_ICYCLE          6'h04
`define TIMER_DIV_SLOW          4'hc
`define TIMER_DIV_FAST          4'h4
`define EXT_MOVE_BASE_CYCLES    4'h2
`define STROBE_WIDTH_ZERO       6'h02
`define STROBE_START_CLK        6'h04

// ==========
// Instruction lengths
`define BYTES_1                 2'h1
`define BYTES_2                 2'h2
`define BYTES_3                 2'h3
`define CYCLES_1                4'h1
`define CYCLES_2                4'h2
`define CYCLES_3                4'h3
`define CYCLES_4                4'h4

`endif

// ==== verilog/branch_decode_pkg.sv ====
// Types shared by the decoder and the sequencer
// Assumes nothing beyond a SystemVerilog compiler
package branch_decode_pkg;

  // ==========
  // Instruction classes
  typedef enum logic [4:0] {
    CLS_OTHER            = 5'h00,
    CLS_BIT_TO_CARRY     = 5'h01,
    CLS_CARRY_TO_BIT     = 5'h02,
    CLS_ABSOLUTE_CALL    = 5'h03,
    CLS_LONG_CALL        = 5'h04,
    CLS_SUB_RETURN       = 5'h05,
    CLS_INT_RETURN       = 5'h06,
    CLS_ABSOLUTE_JUMP    = 5'h07,
    CLS_LONG_JUMP        = 5'h08,
    CLS_SHORT_JUMP       = 5'h09,
    CLS_JUMP_CARRY_SET   = 5'h0a,
    CLS_JUMP_CARRY_CLEAR = 5'h0b,
    CLS_JUMP_BIT_SET     = 5'h0c,
    CLS_JUMP_BIT_CLEAR   = 5'h0d,
    CLS_JUMP_BIT_SET_CLR = 5'h0e,
    CLS_INDIRECT_JUMP    = 5'h0f,
    CLS_JUMP_ACC_ZERO    = 5'h10,
    CLS_JUMP_ACC_NONZERO = 5'h11,
    CLS_COMPARE_JUMP     = 5'h12,
    CLS_DEC_JUMP_NONZERO = 5'h13,
    CLS_NO_OPERATION     = 5'h14,
    CLS_EXT_DATA_MOVE    = 5'h15
  } op_class_t;

  // ==========
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } seq_state_t;

endpackage

// ==== verilog/branch_opcode_decoder.sv ====
// Opcode decoder: class, byte length, cycle count and carry update
// Assumes a stable opcode on its input; purely combinational
`timescale 1ns/10ps
`include "branch_decode_consts.svh"

module branch_opcode_decoder
(
  input  wire logic [7:0]                  i_opcode,
  output branch_decode_pkg::op_class_t     o_class,
  output logic      [1:0]                  o_bytes,
  output logic      [3:0]                  o_cycles,
  output logic                             o_carry_upd,
  output logic                             o_known,
  output logic                             o_ext_move,
  output logic                             o_ext_write
);

  // ==========
  // Decode table
  always_comb
  begin
    o_class     = branch_decode_pkg::CLS_OTHER;
    o_bytes     = `BYTES_1;
    o_cycles    = `CYCLES_1;
    o_carry_upd = 1'b0;
    o_known     = 1'b1;
    casez (i_opcode)
      8'ha2: begin o_class = branch_decode_pkg::CLS_BIT_TO_CARRY; o_bytes = `BYTES_2; o_cycles = `CYCLES_2;
        o_carry_upd = 1'b1; end
      8'h92: begin o_class = branch_decode_pkg::CLS_CARRY_TO_BIT; o_bytes = `BYTES_2; o_cycles = `CYCLES_2; end
      8'h12: begin o_class = branch_decode_pkg::CLS_LONG_CALL; o_bytes = `BYTES_3; o_cycles = `CYCLES_4; end
      8'h22: begin o_class = branch_decode_pkg::CLS_SUB_RETURN; o_bytes = `BYTES_1; o_cycles = `CYCLES_4; end
      8'h32: begin o_class = branch_decode_pkg::CLS_INT_RETURN; o_bytes = `BYTES_1; o_cycles = `CYCLES_4; end
      8'h02: begin o_class = branch_decode_pkg::CLS_LONG_JUMP; o_bytes = `BYTES_3; o_cycles = `CYCLES_4; end
      8'h80: begin o_class = branch_decode_pkg::CLS_SHORT_JUMP; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      8'h40: begin o_class = branch_decode_pkg::CLS_JUMP_CARRY_SET; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      8'h50: begin o_class = branch_decode_pkg::CLS_JUMP_CARRY_CLEAR; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      8'h60: begin o_class = branch_decode_pkg::CLS_JUMP_ACC_ZERO; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      8'h70: begin o_class = branch_decode_pkg::CLS_JUMP_ACC_NONZERO; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      8'h20: begin o_class = branch_decode_pkg::CLS_JUMP_BIT_SET; o_bytes = `BYTES_3; o_cycles = `CYCLES_4; end
      8'h30: begin o_class = branch_decode_pkg::CLS_JUMP_BIT_CLEAR; o_bytes = `BYTES_3; o_cycles = `CYCLES_4; end
      8'h10: begin o_class = branch_decode_pkg::CLS_JUMP_BIT_SET_CLR; o_bytes = `BYTES_3; o_cycles = `CYCLES_4; end
      8'h73: begin o_class = branch_decode_pkg::CLS_INDIRECT_JUMP; o_bytes = `BYTES_1; o_cycles = `CYCLES_3; end
      8'hb4,
      8'hb5,
      8'b1011_011?,
      8'b1011_1???: begin o_class = branch_decode_pkg::CLS_COMPARE_JUMP; o_bytes = `BYTES_3; o_cycles = `CYCLES_4;
        o_carry_upd = 1'b1; end
      8'b1101_1???: begin o_class = branch_decode_pkg::CLS_DEC_JUMP_NONZERO; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      8'hd5: begin o_class = branch_decode_pkg::CLS_DEC_JUMP_NONZERO; o_bytes = `BYTES_3; o_cycles = `CYCLES_4; end
      8'h00,
      8'ha5: o_class = branch_decode_pkg::CLS_NO_OPERATION;
      8'b111?_0000,
      8'b111?_001?: begin o_class = branch_decode_pkg::CLS_EXT_DATA_MOVE; o_bytes = `BYTES_1;
        o_cycles = `EXT_MOVE_BASE_CYCLES; end
      8'b???1_0001: begin o_class = branch_decode_pkg::CLS_ABSOLUTE_CALL; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      8'b???0_0001: begin o_class = branch_decode_pkg::CLS_ABSOLUTE_JUMP; o_bytes = `BYTES_2; o_cycles = `CYCLES_3; end
      default: o_known = 1'b0;
    endcase
  end

  assign o_ext_move  = (o_class == branch_decode_pkg::CLS_EXT_DATA_MOVE);
  assign o_ext_write = o_ext_move & i_opcode[4];

endmodule // branch_opcode_decoder

// ==== verilog/branch_decode_and_stretch_timing.sv ====
// Branch decode, instruction cycle sequencing, timer prescale and stretched external data strobes
// Assumes opcodes, special function writes and external read data synchronous to I_CLK_SYS
//
// Operation
// - Decode bit/carry moves, two bytes, two cycles
// - Decode absolute call and jump, 2B/3C
// - Long call 3B/4C, returns 1B/4C
// - Long jump 3B/4C, short jump 2B/3C
// - Carry and accumulator jumps, two bytes, three cycles
// - Bit test jumps, three bytes, four cycles
// - Indirect jump one byte, three cycles
// - Compare jumps 3B/4C, update carry
// - Decrement jumps: register 2B/3C, direct 3B/4C
// - Opcodes 00 and A5 are no-operation
// - Instruction cycle is four clocks long
// - Timer tick every 12 clocks, or 4
// - External move two cycles minimum; fetches unstretched
// - Stretch 0-7 from clock control low bits
// - Stretch resets to one
// - Stretch changes apply to later moves
// - Strobe width 2 clocks, else 4 per unit
// - Clock select bits 4:3, reset 00
`timescale 1ns/10ps
`include "branch_decode_consts.svh"

module branch_decode_and_stretch_timing
(
  input  wire logic                         I_CLK_SYS,
  input  wire logic                         I_SYS_RST,
  // Instruction issue
  input  wire logic                         I_OP_VALID,
  input  wire logic [7:0]                   I_OPCODE,
  output logic                              O_OP_READY,
  output branch_decode_pkg::op_class_t      O_CLASS,
  output logic      [1:0]                   O_BYTES,
  output logic      [3:0]                   O_CYCLES,
  output logic                              O_CARRY_UPD,
  output logic                              O_KNOWN,
  output logic                              O_BUSY,
  output logic                              O_ICYCLE_END,
  output logic                              O_DONE,
  // Special function space port
  input  wire logic                         I_SFR_WR,
  input  wire logic                         I_SFR_RD,
  input  wire logic [7:0]                   I_SFR_ADDR,
  input  wire logic [7:0]                   I_SFR_WDATA,
  output logic      [7:0]                   O_SFR_RDATA,
  // CPU control register port
  input  wire logic                         I_CPUCTL_WR,
  input  wire logic [7:0]                   I_CPUCTL_WDATA,
  output logic      [7:0]                   O_CPUCTL_RDATA,
  output logic      [1:0]                   O_CPU_CLK_SEL,
  // Timer prescale
  output logic                              O_TIMER_TICK,
  // External data memory
  input  wire logic [15:0]                  I_XD_ADDR,
  input  wire logic [7:0]                   I_XD_WDATA,
  input  wire logic [7:0]                   I_XD_RDATA,
  output logic      [15:0]                  O_XD_ADDR,
  output logic      [7:0]                   O_XD_WDATA,
  output logic      [7:0]                   O_XD_RDATA,
  output logic                              O_XD_RDATA_VALID,
  output logic                              O_XD_RD_N,
  output logic                              O_XD_WR_N
);

  // ==========
  // Functions
  function automatic logic [5:0] strobe_width(input logic [2:0] stretch);
    logic [5:0] w;
    w = {1'b0, stretch, 2'b00};
    if (stretch == 3'h0)
      w = `STROBE_WIDTH_ZERO;
    return w;
  endfunction

  function automatic logic [5:0] cycles_to_clocks(input logic [3:0] cyc);
    logic [5:0] c;
    c = 6'({cyc, 2'b00});
    return c;
  endfunction

  // ==========
  // Declarations
  branch_decode_pkg::op_class_t dec_class;
  logic      [1:0]              dec_bytes;
  logic      [3:0]              dec_cycles;
  logic                         dec_carry_upd;
  logic                         dec_known;
  logic                         dec_ext_move;
  logic                         dec_ext_write;

  branch_decode_pkg::seq_state_t state_ff;
  branch_decode_pkg::seq_state_t nxt_state;

  logic [7:0] clock_control_stretch_ff;
  logic [7:0] nxt_clock_control_stretch;
  logic [7:0] cpu_control_clock_select_ff;
  logic [7:0] nxt_cpu_control_clock_select;

  logic [5:0] clk_cnt_ff;
  logic [5:0] nxt_clk_cnt;
  logic [5:0] total_clks_ff;
  logic [5:0] nxt_total_clks;
  logic [5:0] strobe_end_ff;
  logic [5:0] nxt_strobe_end;
  logic       ext_move_ff;
  logic       ext_write_ff;

  branch_decode_pkg::op_class_t class_ff;
  logic      [1:0]              bytes_ff;
  logic      [3:0]              cycles_ff;
  logic                         carry_upd_ff;
  logic                         known_ff;
  logic                         done_ff;
  logic      [15:0]             xd_addr_ff;
  logic      [7:0]              xd_wdata_ff;
  logic      [7:0]              xd_rdata_ff;
  logic                         xd_rdata_valid_ff;
  logic      [7:0]              sfr_rdata_ff;

  logic [3:0] tmr_cnt_ff;
  logic [3:0] nxt_tmr_cnt;
  logic       tick_ff;

  logic [2:0] stretch_field;
  logic       timer_fast;
  logic [3:0] issue_cycles;
  logic       issue;
  logic       last_clk;
  logic       icycle_end;
  logic       strobe_active;
  logic       strobe_last;
  logic       sfr_ctl_hit;
  logic [1:0] clksel_wr;
  logic       clksel_legal;
  logic [3:0] tmr_div;
  logic       tmr_wrap;

  // ==========
  // Decoder
  branch_opcode_decoder u_decoder
  (
    .i_opcode    (I_OPCODE),
    .o_class     (dec_class),
    .o_bytes     (dec_bytes),
    .o_cycles    (dec_cycles),
    .o_carry_upd (dec_carry_upd),
    .o_known     (dec_known),
    .o_ext_move  (dec_ext_move),
    .o_ext_write (dec_ext_write)
  );

  // ==========
  // Register decode
  assign stretch_field = clock_control_stretch_ff[`STRETCH_MSB:`STRETCH_LSB];
  assign timer_fast    = clock_control_stretch_ff[`TIMER_FAST_BIT];
  assign sfr_ctl_hit   = (I_SFR_ADDR == `SFR_CLOCK_CONTROL_ADDR);
  assign clksel_wr     = I_CPUCTL_WDATA[`CLKSEL_MSB:`CLKSEL_LSB];
  assign clksel_legal  = (clksel_wr == `CLKSEL_12MHZ) | (clksel_wr == `CLKSEL_24MHZ) |
                         (clksel_wr == `CLKSEL_48MHZ);

  assign nxt_clock_control_stretch = (I_SFR_WR & sfr_ctl_hit) ? I_SFR_WDATA
                                                               : clock_control_stretch_ff;

  assign nxt_cpu_control_clock_select = (I_CPUCTL_WR & clksel_legal) ? I_CPUCTL_WDATA
                                                                      : cpu_control_clock_select_ff;

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      clock_control_stretch_ff    <= `CLOCK_CONTROL_RESET;
      cpu_control_clock_select_ff <= `CPU_CONTROL_RESET;
    end
    else
    begin
      clock_control_stretch_ff    <= nxt_clock_control_stretch;
      cpu_control_clock_select_ff <= nxt_cpu_control_clock_select;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      sfr_rdata_ff <= 8'h00;
    else if (I_SFR_RD)
      sfr_rdata_ff <= sfr_ctl_hit ? clock_control_stretch_ff : 8'h00;
  end

  assign O_SFR_RDATA    = sfr_rdata_ff;
  assign O_CPUCTL_RDATA = cpu_control_clock_select_ff;
  assign O_CPU_CLK_SEL  = cpu_control_clock_select_ff[`CLKSEL_MSB:`CLKSEL_LSB];

  // ==========
  // Timer prescale
  assign tmr_div     = timer_fast ? `TIMER_DIV_FAST : `TIMER_DIV_SLOW;
  assign tmr_wrap    = (tmr_cnt_ff >= (tmr_div - 4'h1));
  assign nxt_tmr_cnt = tmr_wrap ? 4'h0 : (tmr_cnt_ff + 4'h1);

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      tmr_cnt_ff <= 4'h0;
      tick_ff    <= 1'b0;
    end
    else
    begin
      tmr_cnt_ff <= nxt_tmr_cnt;
      tick_ff    <= tmr_wrap;
    end
  end

  assign O_TIMER_TICK = tick_ff;

  // ==========
  // Sequencer control
  assign issue        = (state_ff == branch_decode_pkg::ST_IDLE) & I_OP_VALID;
  assign issue_cycles = dec_ext_move ? (dec_cycles + {1'b0, stretch_field}) : dec_cycles;
  assign last_clk     = (clk_cnt_ff == (total_clks_ff - 6'h01));
  assign icycle_end   = (state_ff == branch_decode_pkg::ST_EXEC) &
                        (clk_cnt_ff[1:0] == 2'(`CLK_PER_ICYCLE - 6'h01));

  assign nxt_total_clks = issue ? cycles_to_clocks(issue_cycles) : total_clks_ff;
  assign nxt_strobe_end = issue ? (`STROBE_START_CLK + strobe_width(stretch_field)) : strobe_end_ff;

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_clk_cnt = clk_cnt_ff;
    unique case (state_ff)
      branch_decode_pkg::ST_IDLE:
      begin
        nxt_clk_cnt = 6'h00;
        if (I_OP_VALID)
          nxt_state = branch_decode_pkg::ST_EXEC;
      end
      branch_decode_pkg::ST_EXEC:
      begin
        nxt_clk_cnt = clk_cnt_ff + 6'h01;
        if (last_clk)
        begin
          nxt_state   = branch_decode_pkg::ST_IDLE;
          nxt_clk_cnt = 6'h00;
        end
      end
      default:
      begin
        nxt_state   = branch_decode_pkg::ST_IDLE;
        nxt_clk_cnt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_ff      <= branch_decode_pkg::ST_IDLE;
      clk_cnt_ff    <= 6'h00;
      total_clks_ff <= 6'h00;
      strobe_end_ff <= 6'h00;
      done_ff       <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      clk_cnt_ff    <= nxt_clk_cnt;
      total_clks_ff <= nxt_total_clks;
      strobe_end_ff <= nxt_strobe_end;
      done_ff       <= (state_ff == branch_decode_pkg::ST_EXEC) & last_clk;
    end
  end

  // ==========
  // Decode result capture
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      class_ff     <= branch_decode_pkg::CLS_OTHER;
      bytes_ff     <= 2'h0;
      cycles_ff    <= 4'h0;
      carry_upd_ff <= 1'b0;
      known_ff     <= 1'b0;
      ext_move_ff  <= 1'b0;
      ext_write_ff <= 1'b0;
    end
    else if (issue)
    begin
      class_ff     <= dec_class;
      bytes_ff     <= dec_bytes;
      cycles_ff    <= issue_cycles;
      carry_upd_ff <= dec_carry_upd;
      known_ff     <= dec_known;
      ext_move_ff  <= dec_ext_move;
      ext_write_ff <= dec_ext_write;
    end
  end

  assign O_OP_READY   = (state_ff == branch_decode_pkg::ST_IDLE);
  assign O_BUSY       = (state_ff == branch_decode_pkg::ST_EXEC);
  assign O_ICYCLE_END = icycle_end;
  assign O_DONE       = done_ff;
  assign O_CLASS      = class_ff;
  assign O_BYTES      = bytes_ff;
  assign O_CYCLES     = cycles_ff;
  assign O_CARRY_UPD  = carry_upd_ff;
  assign O_KNOWN      = known_ff;

  // ==========
  // External data strobe
  assign strobe_active = (state_ff == branch_decode_pkg::ST_EXEC) & ext_move_ff &
                         (clk_cnt_ff >= `STROBE_START_CLK) & (clk_cnt_ff < strobe_end_ff);
  assign strobe_last   = strobe_active & (clk_cnt_ff == (strobe_end_ff - 6'h01));

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      xd_addr_ff  <= 16'h0000;
      xd_wdata_ff <= 8'h00;
    end
    else if (issue & dec_ext_move)
    begin
      xd_addr_ff  <= I_XD_ADDR;
      xd_wdata_ff <= I_XD_WDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      xd_rdata_ff       <= 8'h00;
      xd_rdata_valid_ff <= 1'b0;
    end
    else
    begin
      xd_rdata_valid_ff <= strobe_last & ~ext_write_ff;
      if (strobe_last & ~ext_write_ff)
        xd_rdata_ff <= I_XD_RDATA;
    end
  end

  assign O_XD_ADDR        = xd_addr_ff;
  assign O_XD_WDATA       = xd_wdata_ff;
  assign O_XD_RDATA       = xd_rdata_ff;
  assign O_XD_RDATA_VALID = xd_rdata_valid_ff;
  assign O_XD_RD_N        = ~(strobe_active & ~ext_write_ff);
  assign O_XD_WR_N        = ~(strobe_active & ext_write_ff);

endmodule // branch_decode_and_stretch_timing

// ==== verification/branch_decode_assertions.sv ====
// Checker for the branch decode and stretch timing block
// Assumes binding to the top module; sees only its ports
`timescale 1ns/10ps
module branch_decode_checker
(
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_SYS_RST,
  input  wire logic       I_OP_VALID,
  input  wire logic [7:0] I_OPCODE,
  input  wire logic       O_OP_READY,
  input  wire logic [3:0] O_CYCLES,
  input  wire logic       O_BUSY,
  input  wire logic       O_ICYCLE_END,
  input  wire logic       O_DONE,
  input  wire logic       I_SFR_WR,
  input  wire logic       I_SFR_RD,
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic [7:0] I_SFR_WDATA,
  input  wire logic [7:0] O_SFR_RDATA,
  input  wire logic       I_CPUCTL_WR,
  input  wire logic [7:0] I_CPUCTL_WDATA,
  input  wire logic [7:0] O_CPUCTL_RDATA,
  input  wire logic [1:0] O_CPU_CLK_SEL,
  input  wire logic       O_TIMER_TICK,
  input  wire logic       O_XD_RD_N,
  input  wire logic       O_XD_WR_N
);
  // ==========
  // Mirrors and counters
  logic [7:0] ck_ff;
  logic [2:0] mv_ff;
  logic [5:0] lo_ff;
  logic [5:0] bc_ff;
  logic [3:0] tc_ff;
  logic [4:0] cc_ff;
  wire        issue    = O_OP_READY && I_OP_VALID;
  wire        strobe_n = O_XD_RD_N && O_XD_WR_N;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
    if (I_SYS_RST)
    begin
      ck_ff <= 8'h01;
      mv_ff <= 3'h1;
      lo_ff <= 6'h00;
      bc_ff <= 6'h00;
      tc_ff <= 4'h0;
      cc_ff <= 5'h00;
    end
    else
    begin
      if (I_SFR_WR && I_SFR_ADDR == 8'h8e)
        ck_ff <= I_SFR_WDATA;
      if (issue)
        mv_ff <= ck_ff[2:0];
      lo_ff <= strobe_n ? 6'h00 : lo_ff + 6'h01;
      bc_ff <= O_BUSY ? bc_ff + 6'h01 : 6'h00;
      tc_ff <= O_TIMER_TICK ? 4'h0 : tc_ff + 4'h1;
      cc_ff <= I_SFR_WR ? 5'h00 : (cc_ff == 5'h1f ? cc_ff : cc_ff + 5'h01);
    end
  // ==========
  // Properties
  nop_length_a: assert property (issue && I_OPCODE == 8'h00 |=> !O_DONE[*4] ##1 O_DONE)
    else $error("no-operation length wrong");
  icycle_end_a: assert property ($rose(O_BUSY) |-> !O_ICYCLE_END[*3] ##1 O_ICYCLE_END)
    else $error("instruction cycle not four clocks");
  busy_length_a: assert property ($fell(O_BUSY) |-> bc_ff == {O_CYCLES, 2'b00})
    else $error("busy length differs from cycle count");
  strobe_start_a: assert property (issue && I_OPCODE == 8'he0 |=> O_XD_RD_N[*4] ##1 !O_XD_RD_N)
    else $error("read strobe start wrong");
  strobe_width_a: assert property (!strobe_n ##1 strobe_n |->
    lo_ff == (mv_ff == 3'h0 ? 6'h02 : {1'b0, mv_ff, 2'b00})) else $error("strobe width wrong");
  tick_gap_a: assert property (O_TIMER_TICK && cc_ff == 5'h1f |-> tc_ff == (ck_ff[3] ? 4'h3 : 4'hb))
    else $error("timer tick spacing wrong");
  stretch_read_a: assert property (I_SFR_RD && I_SFR_ADDR == 8'h8e |=> O_SFR_RDATA == $past(ck_ff))
    else $error("clock control read wrong");
  unmapped_read_a: assert property (I_SFR_RD && I_SFR_ADDR != 8'h8e |=> O_SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  cpuctl_write_a: assert property (I_CPUCTL_WR && I_CPUCTL_WDATA[4:3] != 2'h3 |=>
    O_CPUCTL_RDATA == $past(I_CPUCTL_WDATA) && O_CPU_CLK_SEL == O_CPUCTL_RDATA[4:3])
    else $error("cpu control write wrong");
  cpuctl_bad_a: assert property (I_CPUCTL_WR && I_CPUCTL_WDATA[4:3] == 2'h3 |=> $stable(O_CPUCTL_RDATA))
    else $error("reserved clock select taken");
endmodule // branch_decode_checker

bind branch_decode_and_stretch_timing branch_decode_checker chk_i
(
  .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_OP_VALID(I_OP_VALID), .I_OPCODE(I_OPCODE),
  .O_OP_READY(O_OP_READY), .O_CYCLES(O_CYCLES), .O_BUSY(O_BUSY), .O_ICYCLE_END(O_ICYCLE_END),
  .O_DONE(O_DONE), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .I_SFR_ADDR(I_SFR_ADDR),
  .I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA), .I_CPUCTL_WR(I_CPUCTL_WR),
  .I_CPUCTL_WDATA(I_CPUCTL_WDATA), .O_CPUCTL_RDATA(O_CPUCTL_RDATA), .O_CPU_CLK_SEL(O_CPU_CLK_SEL),
  .O_TIMER_TICK(O_TIMER_TICK), .O_XD_RD_N(O_XD_RD_N), .O_XD_WR_N(O_XD_WR_N)
);

// ==== verification/ext_data_memory.sv ====
// Slow external data memory on the far side of the strobes
// Assumes active-low strobes and a registered address from the block
`timescale 1ns/10ps
module ext_data_memory
(
  input  wire logic        i_clk,
  input  wire logic [4:0]  i_lat,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  output logic      [7:0]  o_rdata,
  output logic      [7:0]  o_last_wr
);
  // ==========
  // Data valid after i_lat strobe clocks; released bus toggles
  logic [4:0] n_ff;
  logic [7:0] hold_ff;
  assign o_rdata = (!i_rd_n && n_ff >= i_lat) ? i_addr[7:0] ^ 8'ha5 : ~hold_ff;
  always_ff @(posedge i_clk)
  begin
    hold_ff <= o_rdata;
    n_ff <= i_rd_n ? 5'h00 : n_ff + 5'h01;
    if (!i_wr_n)
      o_last_wr <= i_wdata;
  end
endmodule // ext_data_memory

// ==== verification/test_branch_decode_and_stretch_timing.sv ====
// Self-checking bench for the branch decode and stretch timing block
// Assumes the memory model and the bound checker
`timescale 1ns/10ps
module test_branch_decode_and_stretch_timing;
  logic        clk, rst, vld, swr, srd, cwr, rdn, wrn, xrv, rdy, bsy, dn, cup, kn, tick;
  logic [7:0]  op, sad, swd, srdat, cwd, crd, xw, xr, xrd, xwo, lastw;
  logic [15:0] xa, xao;
  logic [1:0]  byt, csel;
  logic [3:0]  cyc;
  logic [4:0]  lat, cls;
  int          miscompares = 0, comparisons = 0, ticks, tcnt = 0;
  branch_decode_and_stretch_timing uut
  (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_OP_VALID(vld), .I_OPCODE(op), .O_OP_READY(rdy), .O_CLASS(cls),
    .O_BYTES(byt), .O_CYCLES(cyc), .O_CARRY_UPD(cup), .O_KNOWN(kn), .O_BUSY(bsy), .O_ICYCLE_END(),
    .O_DONE(dn), .I_SFR_WR(swr), .I_SFR_RD(srd), .I_SFR_ADDR(sad), .I_SFR_WDATA(swd), .O_SFR_RDATA(srdat),
    .I_CPUCTL_WR(cwr), .I_CPUCTL_WDATA(cwd), .O_CPUCTL_RDATA(crd), .O_CPU_CLK_SEL(csel), .O_TIMER_TICK(tick),
    .I_XD_ADDR(xa), .I_XD_WDATA(xw), .I_XD_RDATA(xr), .O_XD_ADDR(xao), .O_XD_WDATA(xwo), .O_XD_RDATA(xrd),
    .O_XD_RDATA_VALID(xrv), .O_XD_RD_N(rdn), .O_XD_WR_N(wrn)
  );
  ext_data_memory mem (.i_clk(clk), .i_lat(lat), .i_addr(xao), .i_wdata(xwo), .i_rd_n(rdn), .i_wr_n(wrn),
    .o_rdata(xr), .o_last_wr(lastw));
  // ==========
  // Clock, timeout and common tasks
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tcnt++;
    if (tcnt == 20000)
    begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    swr = 1'b1;
    sad = a;
    swd = d;
    @(negedge clk);
    swr = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    srd = 1'b1;
    sad = a;
    @(negedge clk);
    srd = 1'b0;
    chk({8'h00, srdat}, {8'h00, e});
  endtask
  task automatic issue(input logic [7:0] o, input bit late, input logic [7:0] nv);
    int n = 0;
    @(negedge clk);
    vld = 1'b1;
    op = o;
    @(negedge clk);
    vld = 1'b0;
    if (late)
      sfr_wr(8'h8e, nv);
    while (dn !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, dn}, 16'h0001);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    sfr_rd(8'h8e, 8'h01);
    chk({8'h00, crd}, 16'h0000);
    issue(8'he2, 1'b0, 8'h00);
    chk({12'h000, cyc}, 16'h0003);
    sfr_rd(8'h8f, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_decode();
    logic [15:0] tab [32] = '{16'ha222, 16'h9222, 16'h1123, 16'h7123, 16'hf123, 16'h0123, 16'h4123, 16'he123,
      16'h1234, 16'h2214, 16'h3214, 16'h0234, 16'h8023, 16'h4023, 16'h5023, 16'h6023, 16'h7023, 16'h2034,
      16'h3034, 16'h1034, 16'h7313, 16'hb534, 16'hb434, 16'hb834, 16'hbf34, 16'hb634, 16'hb734, 16'hd823,
      16'hdf23, 16'hd534, 16'h0011, 16'ha511};
    foreach (tab[i])
    begin
      issue(tab[i][15:8], 1'b0, 8'h00);
      chk({14'h0000, byt}, {12'h000, tab[i][7:4]});
      chk({12'h000, cyc}, {12'h000, tab[i][3:0]});
      chk({14'h0000, cup, kn}, {14'h0000, tab[i][15:8] == 8'ha2 || tab[i][15:12] == 4'hb, 1'b1});
      if (tab[i][3:0] == 4'h1)
        chk({11'h000, cls}, {11'h000, branch_decode_pkg::CLS_NO_OPERATION});
    end
    $display("test decode done");
  endtask
  task automatic t_stretch();
    logic [2:0] sv [4] = '{3'h0, 3'h7, 3'h2, 3'h1};
    foreach (sv[i])
    begin
      sfr_wr(8'h8e, {5'h00, sv[i]});
      lat = i[0] ? 5'h00 : (sv[i] == 3'h0 ? 5'h01 : {sv[i], 2'b00} - 5'h01);
      xa = {8'h12, 5'h00, sv[i]};
      xw = ~xa[7:0];
      issue(8'he0, 1'b0, 8'h00);
      chk({12'h000, cyc}, {13'h0000, sv[i]} + 16'h0002);
      chk({8'h00, xrd}, {8'h00, xa[7:0] ^ 8'ha5});
      issue(8'hf2, 1'b1, 8'h03);
      chk({12'h000, cyc}, {13'h0000, sv[i]} + 16'h0002);
      chk({8'h00, lastw}, {8'h00, xw});
    end
    $display("test stretch done");
  endtask
  task automatic t_timer();
    for (int k = 0; k < 2; k++)
    begin
      sfr_wr(8'h8e, k ? 8'h00 : 8'h08);
      repeat (40) @(negedge clk);
      ticks = 0;
      repeat (48)
      begin
        @(negedge clk);
        ticks += tick;
      end
      chk(ticks[15:0], k ? 16'h0004 : 16'h000c);
    end
    $display("test timer done");
  endtask
  task automatic t_cpuctl();
    logic [7:0] w [4] = '{8'h08, 8'h10, 8'h18, 8'h00};
    foreach (w[i])
    begin
      @(negedge clk);
      cwr = 1'b1;
      cwd = w[i];
      @(negedge clk);
      cwr = 1'b0;
      chk({8'h00, crd}, {8'h00, w[i] == 8'h18 ? 8'h10 : w[i]});
      chk({14'h0000, csel}, {14'h0000, w[i] == 8'h18 ? 2'h2 : w[i][4:3]});
    end
    $display("test cpu control done");
  endtask
  initial
  begin
    rst = 1'b1;
    vld = 1'b0;
    op = 8'h00;
    swr = 1'b0;
    srd = 1'b0;
    sad = 8'h00;
    swd = 8'h00;
    cwr = 1'b0;
    cwd = 8'h00;
    xa = 16'h0040;
    xw = 8'h00;
    lat = 5'h03;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_decode();
    t_stretch();
    t_timer();
    t_cpuctl();
    results();
  end
endmodule // test_branch_decode_and_stretch_timing
